// *** bench/tb_reset_cause_recorder.sv ***
// Self-checking testbench of the reset cause recorder.
`timescale 1ns/1ps
`include "reset_cause_map.svh"

module tb_reset_cause_recorder;
  localparam int PC_W = 15;
  logic                           aclk, aresetn;
  logic [7:0]                     awaddr, araddr;
  logic                           awvalid, awready, wvalid, wready, bvalid, bready;
  logic                           arvalid, arready, rvalid, rready;
  logic [31:0]                    wdata, rdata, rd;
  logic [3:0]                     wstrb;
  logic [1:0]                     bresp, rresp;
  reset_cause_pkg::reset_events_t events;
  logic                           sleeping, global_int_enable, instr_done;
  logic [PC_W-1:0]                current_pc, pc_load_addr, push_addr, exp_addr;
  logic                           pc_load, push_return, timeout_flag, powerdown_flag, irq;
  int                             num_errors, checked;
  integer                         seed;
  logic [7:0]                     pf;
  logic [10:0]                    ist, mask;
  logic                           mviol, tmo, pdown, se, load;

  reset_cause_recorder #(.PC_W(PC_W)) uut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .events(events),
    .sleeping(sleeping), .global_int_enable(global_int_enable), .current_pc(current_pc),
    .instr_done(instr_done), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
    .push_return(push_return), .push_addr(push_addr), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .irq(irq));

  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end

  // ****************************************
  // Checking, bus and model helpers
  // ****************************************
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // The master waits as long as the slave needs; only the watchdog ends a hang.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    check("bresp", {30'h0, bresp}, {30'h0, er});
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    rready <= 1'h0;
    check("rresp", {30'h0, rresp}, {30'h0, er});
  endtask : axi_read

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    axi_read(a, `RESP_OKAY, rd);
    check(what, rd, exp);
  endtask : rdchk

  // Applies one event vector to the expected state in the order the block resolves clashes.
  function automatic void model_step(input reset_cause_pkg::reset_events_t e, input logic slp);
    logic rst;
    rst = 1'h0;
    ist = ist | e;
    if (e.int_wake) begin tmo = 1'h1; pdown = 1'h0; end
    if (e.pin_reset) begin
      pf[3] = 1'h0;
      rst = 1'h1;
      if (slp) begin tmo = 1'h1; pdown = 1'h0; end
      else mviol = 1'h1;
    end
    if (e.wdt_wake) begin tmo = 1'h0; pdown = 1'h0; end
    if (e.wdt_timeout) begin pf[4] = 1'h0; tmo = 1'h0; rst = 1'h1; end
    if (e.wdt_window) begin pf[5] = 1'h0; rst = 1'h1; end
    if (e.reset_instr) begin pf[2] = 1'h0; rst = 1'h1; end
    if (se && e.stack_over) begin pf[7] = 1'h1; rst = 1'h1; end
    if (se && e.stack_under) begin pf[6] = 1'h1; rst = 1'h1; end
    if (e.mem_violation) begin mviol = 1'h0; rst = 1'h1; end
    if (e.brown_out) begin pf = {6'h0F, pf[1], 1'h0}; tmo = 1'h1; pdown = 1'h1; rst = 1'h1; end
    if (e.power_on) begin pf = 8'h3C; mviol = 1'h1; tmo = 1'h1; pdown = 1'h1; rst = 1'h1; end
    load = rst | e.wdt_wake | e.int_wake;
    exp_addr = rst ? '0 : current_pc + 1'h1;
  endfunction : model_step

  task automatic compare_state();
    rdchk("power_control_first", `PWR_FIRST_OFS, {24'h0, pf});
    rdchk("power_control_second", `PWR_SECOND_OFS, {30'h0, mviol, 1'h0});
    rdchk("status", `STATUS_OFS, {27'h0, tmo, pdown, 3'h0});
    check("timeout_flag", {31'h0, timeout_flag}, {31'h0, tmo});
    check("powerdown_flag", {31'h0, powerdown_flag}, {31'h0, pdown});
    rdchk("irq_status", `IRQ_STATUS_OFS, {21'h0, ist});
  endtask : compare_state

  task automatic fire(input reset_cause_pkg::reset_events_t e, input logic slp);
    @(posedge aclk);
    events <= e;
    sleeping <= slp;
    @(posedge aclk);
    events <= '0;
    #1;
    model_step(e, slp);
    check("pc_load", {31'h0, pc_load}, {31'h0, load});
    if (load) check("pc_load_addr", {17'h0, pc_load_addr}, {17'h0, exp_addr});
    check("irq", {31'h0, irq}, {31'h0, |(ist & mask)});
    @(posedge aclk);
    #1;
    check("pc_load_pulse", {31'h0, pc_load}, 32'h0);
    compare_state();
    axi_write(`IRQ_STATUS_OFS, 32'h7FF, `RESP_OKAY);
    ist = '0;
    #1;
    check("irq_cleared", {31'h0, irq}, 32'h0);
  endtask : fire

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [10:0] corner [6];
    logic [10:0] e;
    logic        slp;
    corner = '{11'h400, 11'h0E0, 11'h104, 11'h018, 11'h200, 11'h040};
    seed = 32'hda0f2ae1;
    {aresetn, awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, events, sleeping, global_int_enable} = '0;
    {current_pc, instr_done} = '0;
    {pf, mviol, tmo, pdown, ist, mask, se} = {8'h3C, 3'h7, 22'h0, 1'h0};
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    compare_state();
    rdchk("control", `CONTROL_OFS, 32'h0);
    rdchk("irq_mask", `IRQ_MASK_OFS, 32'h0);
    axi_read(8'h18, `RESP_SLVERR, rd);
    check("unmapped_rdata", rd, 32'h0);
    axi_write(8'h18, 32'hFF, `RESP_SLVERR);
    axi_write(`STATUS_OFS, 32'h0, `RESP_OKAY);
    compare_state();
    $display("Test reset_values done");
    se = 1'h1;
    mask = 11'h7FF;
    axi_write(`CONTROL_OFS, 32'h1, `RESP_OKAY);
    axi_write(`IRQ_MASK_OFS, 32'h7FF, `RESP_OKAY);
    for (int k = 0; k < 6; k++) begin
      pf = 8'h3F;
      axi_write(`PWR_FIRST_OFS, 32'h3F, `RESP_OKAY);
      fire(corner[k], k == 5);
    end
    $display("Test corner_events done");
    global_int_enable <= 1'h1;
    current_pc <= 15'h7FFE;
    fire(11'h001, 1'h1);
    @(posedge aclk);
    instr_done <= 1'h1;
    @(posedge aclk);
    instr_done <= 1'h0;
    #1;
    check("vector_load", {31'h0, pc_load}, 32'h1);
    check("vector_addr", {17'h0, pc_load_addr}, {16'h0, `INT_VECTOR});
    check("push_return", {31'h0, push_return}, 32'h1);
    check("push_addr", {17'h0, push_addr}, 32'h0);
    global_int_enable <= 1'h0;
    fire(11'h001, 1'h1);
    @(posedge aclk);
    instr_done <= 1'h1;
    @(posedge aclk);
    instr_done <= 1'h0;
    #1;
    check("no_vector", {31'h0, pc_load}, 32'h0);
    $display("Test interrupt_vector done");
    for (int i = 0; i < 40; i++) begin
      pf = 8'($random(seed));
      mviol = 1'($random(seed));
      se = 1'($random(seed));
      mask = 11'($random(seed));
      axi_write(`PWR_FIRST_OFS, {24'h0, pf}, `RESP_OKAY);
      axi_write(`PWR_SECOND_OFS, {30'h0, mviol, 1'h0}, `RESP_OKAY);
      axi_write(`CONTROL_OFS, {31'h0, se}, `RESP_OKAY);
      axi_write(`IRQ_MASK_OFS, {21'h0, mask}, `RESP_OKAY);
      current_pc <= 15'($random(seed));
      e = 11'h1 << ($unsigned($random(seed)) % 11);
      slp = (e[1] | e[0]) ? 1'h1 : 1'($random(seed));
      fire(e, slp);
    end
    $display("Test random_events done");
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    finish_test();
  end
endmodule : tb_reset_cause_recorder

// *** rtl/reset_cause_map.svh ***
// Register offsets, field positions, reset values and constants of the reset cause recorder.
`ifndef RESET_CAUSE_MAP_SVH
`define RESET_CAUSE_MAP_SVH

`define PWR_FIRST_OFS    8'h00
`define PWR_SECOND_OFS   8'h04
`define STATUS_OFS       8'h08
`define CONTROL_OFS      8'h0C
`define IRQ_STATUS_OFS   8'h10
`define IRQ_MASK_OFS     8'h14

`define BIT_STACK_OVER   7
`define BIT_STACK_UNDER  6
`define BIT_WINDOW       5
`define BIT_WATCHDOG     4
`define BIT_PIN          3
`define BIT_INSTR        2
`define BIT_POWERON      1
`define BIT_BROWNOUT     0
`define BIT_MEM_VIOL     1
`define BIT_TIMEOUT      4
`define BIT_POWERDOWN    3
`define BIT_STACK_EN     0

`define PWR_FIRST_POR    8'h3C
`define BROWNOUT_HIGH_BITS 6'h0F
`define INT_VECTOR       16'h0004
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// *** rtl/reset_cause_pkg.sv ***
// Types shared by the reset cause recorder.
package reset_cause_pkg;

  // Each field is a one-cycle event pulse from its source.
  typedef struct packed {
    logic power_on;
    logic brown_out;
    logic wdt_timeout;
    logic wdt_window;
    logic pin_reset;
    logic reset_instr;
    logic stack_over;
    logic stack_under;
    logic mem_violation;
    logic wdt_wake;
    logic int_wake;
  } reset_events_t;

  typedef enum logic {
    VEC_IDLE,
    VEC_WAIT
  } vec_state_t;

endpackage : reset_cause_pkg

// *** rtl/reset_cause_recorder.sv ***
// Reset cause recorder with AXI4-Lite register access and wake-up program counter control.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "reset_cause_map.svh"

module reset_cause_recorder #(
  parameter int PC_W = 15
) (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]                    awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]                    araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  // Reset and wake sources
  input  wire reset_cause_pkg::reset_events_t events,
  input  wire logic                          sleeping,
  input  wire logic                          global_int_enable,
  // Core program counter
  input  wire logic [PC_W-1:0]               current_pc,
  input  wire logic                          instr_done,
  output logic                               pc_load,
  output logic [PC_W-1:0]                    pc_load_addr,
  output logic                               push_return,
  output logic [PC_W-1:0]                    push_addr,
  // Flags and interrupt
  output logic                               timeout_flag,
  output logic                               powerdown_flag,
  output logic                               irq
);

  typedef struct packed {
    logic [7:0]                  power_control_first;
    logic                        memory_violation_flag;
    logic                        timeout_flag;
    logic                        powerdown_flag;
    logic                        stack_reset_enable;
    logic [10:0]                 irq_status;
    logic [10:0]                 irq_mask;
    logic                        irq;
    logic                        aw_held;
    logic [7:0]                  aw_addr;
    logic                        w_held;
    logic [31:0]                 w_data;
    logic [3:0]                  w_strb;
    logic                        awready;
    logic                        wready;
    logic                        bvalid;
    logic [1:0]                  bresp;
    logic                        arready;
    logic                        rvalid;
    logic [31:0]                 rdata;
    logic [1:0]                  rresp;
    reset_cause_pkg::vec_state_t vec_state;
    logic [PC_W-1:0]             ret_addr;
    logic                        pc_load;
    logic [PC_W-1:0]             pc_load_addr;
    logic                        push_return;
    logic [PC_W-1:0]             push_addr;
  } state_t;

  state_t st;
  state_t next_st;
  logic   any_reset;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  function automatic logic [PC_W-1:0] next_addr(input logic [PC_W-1:0] a);
    return a + {{(PC_W-1){1'b0}}, 1'b1};
  endfunction : next_addr

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] a);
    return (a == `PWR_FIRST_OFS) || (a == `PWR_SECOND_OFS) || (a == `STATUS_OFS) ||
           (a == `CONTROL_OFS) || (a == `IRQ_STATUS_OFS) || (a == `IRQ_MASK_OFS);
  endfunction : mapped

  // Stack events only restart the core when the stack reset is enabled.
  assign any_reset = events.power_on | events.brown_out | events.wdt_timeout |
                     events.wdt_window | events.pin_reset | events.reset_instr |
                     events.mem_violation |
                     (st.stack_reset_enable & (events.stack_over | events.stack_under));

  // ****************************************************************
  // Next state
  // ****************************************************************

  always_comb begin
    logic [31:0] wr;
    logic [31:0] mask_wr;
    wr = merge(32'h0, st.w_data, st.w_strb);
    // The mask honours lanes 0 and 1; anything above bit 10 is dropped on purpose.
    mask_wr = merge({21'h0, st.irq_mask}, st.w_data, st.w_strb);
    next_st = st;
    next_st.pc_load = 1'b0;
    next_st.push_return = 1'b0;

    if (awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = awaddr;
      next_st.awready = 1'b0;
    end
    if (wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.w_data = wdata;
      next_st.w_strb = wstrb;
      next_st.wready = 1'b0;
    end
    if (st.bvalid && bready) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end

    // Software writes go first so that a hardware event in the same cycle wins.
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = mapped(st.aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
      if (st.w_strb[0]) begin
        unique case (st.aw_addr)
          `PWR_FIRST_OFS: next_st.power_control_first = wr[7:0];
          `PWR_SECOND_OFS: next_st.memory_violation_flag = wr[`BIT_MEM_VIOL];
          `CONTROL_OFS: next_st.stack_reset_enable = wr[`BIT_STACK_EN];
          default: ;
        endcase
      end
      if (st.aw_addr == `IRQ_STATUS_OFS) begin
        next_st.irq_status = st.irq_status & ~wr[10:0];
      end
      if (st.aw_addr == `IRQ_MASK_OFS) begin
        next_st.irq_mask = mask_wr[10:0];
      end
    end

    if (arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      next_st.rdata = 32'h0;
      unique case (araddr)
        `PWR_FIRST_OFS: next_st.rdata[7:0] = st.power_control_first;
        `PWR_SECOND_OFS: next_st.rdata[`BIT_MEM_VIOL] = st.memory_violation_flag;
        `STATUS_OFS: begin
          next_st.rdata[`BIT_TIMEOUT] = st.timeout_flag;
          next_st.rdata[`BIT_POWERDOWN] = st.powerdown_flag;
        end
        `CONTROL_OFS: next_st.rdata[`BIT_STACK_EN] = st.stack_reset_enable;
        `IRQ_STATUS_OFS: next_st.rdata[10:0] = st.irq_status;
        `IRQ_MASK_OFS: next_st.rdata[10:0] = st.irq_mask;
        default: ;
      endcase
    end
    if (st.rvalid && rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end

    // Every source applies its own update; later lines win on a shared flag,
    // so power-on, applied last, overwrites everything else; brown-out overwrites all but the memory violation flag and the power-on bit.
    if (events.int_wake) begin
      next_st.timeout_flag = 1'b1;
      next_st.powerdown_flag = 1'b0;
    end
    if (events.pin_reset) begin
      next_st.power_control_first[`BIT_PIN] = 1'b0;
      if (sleeping) begin
        next_st.timeout_flag = 1'b1;
        next_st.powerdown_flag = 1'b0;
      end else begin
        next_st.memory_violation_flag = 1'b1;
      end
    end
    if (events.wdt_wake) begin
      next_st.timeout_flag = 1'b0;
      next_st.powerdown_flag = 1'b0;
    end
    if (events.wdt_timeout) begin
      next_st.power_control_first[`BIT_WATCHDOG] = 1'b0;
      next_st.timeout_flag = 1'b0;
    end
    if (events.wdt_window) begin
      next_st.power_control_first[`BIT_WINDOW] = 1'b0;
    end
    if (events.reset_instr) begin
      next_st.power_control_first[`BIT_INSTR] = 1'b0;
    end
    if (events.stack_over && st.stack_reset_enable) begin
      next_st.power_control_first[`BIT_STACK_OVER] = 1'b1;
    end
    if (events.stack_under && st.stack_reset_enable) begin
      next_st.power_control_first[`BIT_STACK_UNDER] = 1'b1;
    end
    if (events.mem_violation) begin
      next_st.memory_violation_flag = 1'b0;
    end
    if (events.brown_out) begin
      next_st.power_control_first[7:2] = `BROWNOUT_HIGH_BITS;
      next_st.power_control_first[`BIT_BROWNOUT] = 1'b0;
      next_st.timeout_flag = 1'b1;
      next_st.powerdown_flag = 1'b1;
    end
    if (events.power_on) begin
      next_st.power_control_first = `PWR_FIRST_POR;
      next_st.memory_violation_flag = 1'b1;
      next_st.timeout_flag = 1'b1;
      next_st.powerdown_flag = 1'b1;
    end

    // Events are sticky until cleared; a set in the clearing cycle survives.
    next_st.irq_status = next_st.irq_status | events;
    next_st.irq = |(next_st.irq_status & next_st.irq_mask);

    if (any_reset) begin
      next_st.pc_load = 1'b1;
      next_st.pc_load_addr = '0;
      next_st.vec_state = reset_cause_pkg::VEC_IDLE;
    end else if (events.wdt_wake || events.int_wake) begin
      next_st.pc_load = 1'b1;
      next_st.pc_load_addr = next_addr(current_pc);
      if (events.int_wake && global_int_enable) begin
        next_st.vec_state = reset_cause_pkg::VEC_WAIT;
        next_st.ret_addr = next_addr(next_addr(current_pc));
      end
    end else begin
      unique case (st.vec_state)
        reset_cause_pkg::VEC_IDLE: ;
        reset_cause_pkg::VEC_WAIT: begin
          if (instr_done) begin
            next_st.pc_load = 1'b1;
            next_st.pc_load_addr = PC_W'(`INT_VECTOR);
            next_st.push_return = 1'b1;
            next_st.push_addr = st.ret_addr;
            next_st.vec_state = reset_cause_pkg::VEC_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // The bus reset acts as a power-on: the flags take their power-on values.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.power_control_first <= `PWR_FIRST_POR;
      st.memory_violation_flag <= 1'b1;
      st.timeout_flag <= 1'b1;
      st.powerdown_flag <= 1'b1;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.vec_state <= reset_cause_pkg::VEC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign pc_load = st.pc_load;
  assign pc_load_addr = st.pc_load_addr;
  assign push_return = st.push_return;
  assign push_addr = st.push_addr;
  assign timeout_flag = st.timeout_flag;
  assign powerdown_flag = st.powerdown_flag;
  assign irq = st.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic wake_only;
  assign wake_only = !any_reset && (events.wdt_wake || events.int_wake);

  reset_pc_zero_a: assert property (any_reset |=> pc_load && pc_load_addr == '0)
    else $error("reset did not restart at address zero");
  por_values_a: assert property (events.power_on |=> st.power_control_first == `PWR_FIRST_POR
      && st.memory_violation_flag)
    else $error("power-on values wrong");
  por_timeout_a: assert property (events.power_on |=> timeout_flag)
    else $error("timeout flag clear after power-on");
  por_powerdown_a: assert property (events.power_on |=> powerdown_flag)
    else $error("power-down flag clear after power-on");
  bor_values_a: assert property (events.brown_out && !events.power_on |=>
      st.power_control_first[7:2] == `BROWNOUT_HIGH_BITS && !st.power_control_first[0]
      && st.power_control_first[1] == $past(st.power_control_first[1]))
    else $error("brown-out values wrong");
  wdt_timeout_a: assert property (events.wdt_timeout && !events.power_on
      && !events.brown_out |=> !st.power_control_first[`BIT_WATCHDOG] && !timeout_flag)
    else $error("watchdog timeout flags wrong");
  wdt_wake_a: assert property (wake_only && events.wdt_wake |=> pc_load
      && pc_load_addr == $past(current_pc) + 1'b1 && !timeout_flag && !powerdown_flag)
    else $error("watchdog wake handling wrong");
  int_wake_a: assert property (wake_only && events.int_wake && !events.wdt_wake
      |=> timeout_flag && !powerdown_flag && pc_load_addr == $past(current_pc) + 1'b1)
    else $error("interrupt wake handling wrong");
  vector_jump_a: assert property (st.vec_state == reset_cause_pkg::VEC_WAIT
      && instr_done && !any_reset && !events.wdt_wake && !events.int_wake
      |=> push_return && pc_load && pc_load_addr == PC_W'(`INT_VECTOR))
    else $error("interrupt vector not taken");
  pin_clear_a: assert property (events.pin_reset && !events.power_on
      && !events.brown_out |=> !st.power_control_first[`BIT_PIN])
    else $error("pin reset flag not cleared");
  instr_clear_a: assert property (events.reset_instr && !events.power_on
      && !events.brown_out |=> !st.power_control_first[`BIT_INSTR])
    else $error("reset instruction flag not cleared");
  stack_over_a: assert property (events.stack_over && st.stack_reset_enable
      && !events.power_on && !events.brown_out
      |=> st.power_control_first[`BIT_STACK_OVER] && pc_load)
    else $error("stack overflow not recorded");
  mem_clear_a: assert property (events.mem_violation && !events.power_on
      && !events.pin_reset |=> !st.memory_violation_flag && pc_load_addr == '0)
    else $error("memory violation not recorded");

  // The later sources in the update order that override a pin reset's flags are excluded here.
  pin_sleep_a: assert property (events.pin_reset && sleeping && !events.power_on
      && !events.brown_out && !events.wdt_wake && !events.wdt_timeout
      |=> timeout_flag && !powerdown_flag && pc_load_addr == '0)
    else $error("pin reset in sleep flags wrong");
  stack_under_a: assert property (events.stack_under && st.stack_reset_enable
      && !events.power_on && !events.brown_out
      |=> st.power_control_first[`BIT_STACK_UNDER] && pc_load)
    else $error("stack underflow not recorded");
  // The held write data stays put until the response handshake, so no history is needed.
  flag_write_a: assert property (st.aw_held && st.w_held && !st.bvalid
      && st.aw_addr == `PWR_FIRST_OFS && st.w_strb[0] && events == '0
      |=> st.power_control_first == st.w_data[7:0])
    else $error("firmware write to cause flags lost");

  por_seen_c: cover property (events.power_on ##1 pc_load);
  vector_seen_c: cover property (events.int_wake && global_int_enable ##[1:100] push_return);
  irq_seen_c: cover property (!irq ##1 irq);

endmodule : reset_cause_recorder
